// file: data_eeprom_write_guard_test.sv
// data_eeprom_write_guard_test: self-checking bench for dew_guard_top
// assumes short timer counts; APB master and external port driven here
`timescale 1ns/1ps
module data_eeprom_write_guard_test;
  logic                  clock;
  logic                  reset_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  codeProtect;
  logic                  extValid;
  dew_pkg::dew_ext_req_s extReq;
  logic                  extAck;
  logic                  extRefused;
  logic [7:0]            extRdata;
  logic                  lastErr;
  logic [31:0]           r;
  logic                  rf;
  logic [7:0]            rd;
  int                    error_cnt;
  int                    cmp_count;
  int                    cyc;

  dew_guard_top #(.PWRT_CYC(8), .WRITE_CYC(30)) dut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .codeProtect(codeProtect),
    .extValid(extValid), .extReq(extReq), .extAck(extAck),
    .extRefused(extRefused), .extRdata(extRdata));

  dew_ext_prog prog (
    .clock(clock), .extValid(extValid), .extReq(extReq), .extAck(extAck),
    .extRefused(extRefused), .extRdata(extRdata));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one idle cycle before each setup keeps drivers single-assigned
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a hung access
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    do begin
      apb(0, dew_pkg::OFF_CTRL, 0, r);
    end while (r[dew_pkg::CB_WSTART] !== 1'b0);
  endtask : wait_idle

  task automatic set_addr(input logic [9:0] a);
    apb(1, dew_pkg::OFF_ADDR_LO, {24'h0, a[7:0]}, r);
    apb(1, dew_pkg::OFF_ADDR_HI, {30'h0, a[9:8]}, r);
  endtask : set_addr

  task automatic wr_seq(input logic [9:0] a, input logic [7:0] d, input logic [7:0] base,
                        input logic [7:0] k1, input logic [7:0] k2);
    set_addr(a);
    apb(1, dew_pkg::OFF_DATA, {24'h0, d}, r);
    apb(1, dew_pkg::OFF_CTRL, {24'h0, base}, r);
    apb(1, dew_pkg::OFF_UNLOCK, {24'h0, k1}, r);
    apb(1, dew_pkg::OFF_UNLOCK, {24'h0, k2}, r);
    apb(1, dew_pkg::OFF_CTRL, {24'h0, base | 8'h02}, r);
  endtask : wr_seq

  task automatic rd_byte(input logic [9:0] a, output logic [7:0] q);
    set_addr(a);
    // selects cleared first: a fetch looks at the selects already stored
    apb(1, dew_pkg::OFF_CTRL, 32'h0000_0000, r);
    apb(1, dew_pkg::OFF_CTRL, 32'h0000_0001, r);
    apb(0, dew_pkg::OFF_DATA, 0, r);
    q = r[7:0];
  endtask : rd_byte

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    prog.xfer(1, 10'h001, 8'h3C, rf, rd);
    chk("ext write in timer", rf, 1);
    apb(0, dew_pkg::OFF_CTRL, 0, r);
    chk("ctrl after reset", r, 0);
    repeat (10) @(posedge clock);
    apb(0, dew_pkg::OFF_STATUS, 0, r);
    chk("timer done", r[0], 1);
  endtask : t_powerup

  task automatic t_write;
    wr_seq(10'h2A5, 8'hC3, 8'h04, dew_pkg::KEY_FIRST, dew_pkg::KEY_SECOND);
    apb(0, dew_pkg::OFF_CTRL, 0, r);
    chk("busy after start", r[1], 1);
    wait_idle();
    chk("busy clears", r[1], 0);
    rd_byte(10'h2A5, rd);
    chk("readback", rd, 8'hC3);
    rd_byte(10'h0A5, rd);
    chk("high byte used", rd === 8'hC3, 0);
  endtask : t_write

  task automatic t_refused;
    logic [7:0] base [4];
    logic [7:0] k1 [4];
    base = '{8'h04, 8'h00, 8'h84, 8'h44};
    k1 = '{8'hAA, 8'h55, 8'h55, 8'h55};
    for (int i = 0; i < 4; i++) begin
      wr_seq(10'h2A5, 8'h11, base[i], k1[i], ~k1[i]);
      apb(0, dew_pkg::OFF_CTRL, 0, r);
      chk("start refused", r[3:1], {1'b1, base[i][2], 1'b0});
      apb(1, dew_pkg::OFF_CTRL, {24'h0, base[i] | 8'h01}, r);
      apb(0, dew_pkg::OFF_DATA, 0, r);
      chk("fetch only when selected", r[7:0], (base[i][7:6] == 2'b00) ? 8'hC3 : 8'h11);
      rd_byte(10'h2A5, rd);
      chk("array kept", rd, 8'hC3);
    end
  endtask : t_refused

  task automatic t_busy;
    wr_seq(10'h077, 8'h77, 8'h04, 8'h55, 8'hAA);
    wait_idle();
    wr_seq(10'h155, 8'h5A, 8'h04, 8'h55, 8'hAA);
    // second attempt aimed elsewhere while the first runs
    set_addr(10'h077);
    apb(1, dew_pkg::OFF_UNLOCK, 32'h55, r);
    apb(1, dew_pkg::OFF_UNLOCK, 32'hAA, r);
    apb(1, dew_pkg::OFF_CTRL, 32'h06, r);
    wait_idle();
    rd_byte(10'h155, rd);
    chk("running write", rd, 8'h5A);
    rd_byte(10'h077, rd);
    chk("ignored start", rd, 8'h77);
  endtask : t_busy

  task automatic t_protect;
    codeProtect <= 1'b1;
    prog.xfer(0, 10'h155, 8'h00, rf, rd);
    chk("ext read protected", rf, 1);
    prog.xfer(1, 10'h155, 8'h99, rf, rd);
    chk("ext write protected", rf, 1);
    apb(0, dew_pkg::OFF_STATUS, 0, r);
    chk("status protect", r[1:0], 2'b11);
    wr_seq(10'h0FF, 8'h9E, 8'h04, 8'h55, 8'hAA);
    wait_idle();
    rd_byte(10'h0FF, rd);
    chk("internal protected", rd, 8'h9E);
    rd_byte(10'h155, rd);
    chk("ext write blocked", rd, 8'h5A);
    codeProtect <= 1'b0;
    prog.xfer(0, 10'h0FF, 8'h00, rf, rd);
    chk("ext read open", {rf, rd}, {1'b0, 8'h9E});
    prog.xfer(1, 10'h0FF, 8'h24, rf, rd);
    chk("ext write open", rf, 0);
    wait_idle();
    rd_byte(10'h0FF, rd);
    chk("ext write landed", rd, 8'h24);
  endtask : t_protect

  task automatic t_unmapped;
    apb(1, 8'h1C, 32'hFF, r);
    chk("unmapped write err", lastErr, 1);
    apb(0, 8'h18, 0, r);
    chk("unmapped read err", lastErr, 1);
    chk("unmapped read", r, 32'h0);
  endtask : t_unmapped

  ////////////////////////////////////////////////////////////////////////////
  // cut a hang short; whole run needs well under this
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    codeProtect = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_powerup();
    t_write();
    t_refused();
    t_busy();
    t_protect();
    t_unmapped();
    tally_and_finish();
  end
endmodule : data_eeprom_write_guard_test

// file: dew_byte_array.sv
// dew_byte_array: byte array with a timed write and an immediate read port
// assumes the caller never raises wrStart while busy is high
`timescale 1ns/1ps
module dew_byte_array #(
  parameter int AW  = dew_pkg::ADDR_W,
  parameter int DW  = dew_pkg::DATA_W,
  parameter int CYC = dew_pkg::WRITE_CYC
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          wrStart,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData,
  output logic               busy
);

  logic [DW-1:0]            mem [2**AW];
  logic [AW-1:0]            addr_r;
  logic [DW-1:0]            data_r;
  logic [$clog2(CYC+1)-1:0] cnt_r;

  assign rdData = mem[rdAddr];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy  <= 1'b0;
      cnt_r <= '0;
    end else if (wrStart && !busy) begin
      busy  <= 1'b1;
      cnt_r <= '0;
    end else if (busy) begin
      cnt_r <= cnt_r + 1'b1;
      busy  <= (cnt_r != ($clog2(CYC+1))'(CYC - 1));
    end
  end

  // cell contents change only at the end of the write time
  always_ff @(posedge clock) begin
    if (wrStart && !busy) begin
      addr_r <= wrAddr;
      data_r <= wrData;
    end
    if (busy && cnt_r == ($clog2(CYC+1))'(CYC - 1)) begin
      mem[addr_r] <= data_r;
    end
  end

endmodule : dew_byte_array

// file: dew_ext_prog.sv
// dew_ext_prog: model of the external programming port facing the guard
// assumes one clock; called from the bench, one request at a time
`timescale 1ns/1ps
module dew_ext_prog (
  input  wire logic                  clock,
  output logic                       extValid,
  output dew_pkg::dew_ext_req_s      extReq,
  input  wire logic                  extAck,
  input  wire logic                  extRefused,
  input  wire logic [7:0]            extRdata
);
  initial begin
    extValid = 1'b0;
    extReq   = '0;
  end

  // request held until the answer pulse is sampled
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic rf, output logic [7:0] rd);
    @(posedge clock);
    extValid <= 1'b1;
    extReq   <= '{write: w, addr: a, wdata: d};
    // no local limit: only the bench timeout ends a hung request
    do begin
      @(posedge clock);
    end while (!(extAck === 1'b1 || extRefused === 1'b1));
    rf = extRefused;
    rd = extRdata;
    extValid <= 1'b0;
    // released lines show no stale request
    extReq   <= dew_pkg::dew_ext_req_s'(~extReq);
  endtask : xfer
endmodule : dew_ext_prog

// file: dew_guard_top.sv
// dew_guard_top: APB register slave guarding writes to the data EEPROM array
// assumes synchronous inputs, one clock, and an external programming port
// that holds extValid and its request until extAck or extRefused pulses
//
// Functional notes
// - external reads and writes are refused while code protection is on.
// - internal reads and writes ignore the code protection setting.
// - write_permit_bit is cleared at power-up.
// - no array write starts while the power-up timer is running.
// - an internal write starts only with permit set and unlock completed just before.
// - write start reads set while writing and clears itself on completion.
// - byte address is byte_address_high joined with byte_address_low.
// - setting the read bit with EEPROM selected fetches the addressed byte.
`timescale 1ns/1ps
module dew_guard_top #(
  parameter int AW        = dew_pkg::ADDR_W,
  parameter int PWRT_CYC  = dew_pkg::PWRT_CYC,
  parameter int WRITE_CYC = dew_pkg::WRITE_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 codeProtect,
  input  wire logic                 extValid,
  input  wire dew_pkg::dew_ext_req_s extReq,
  output logic                      extAck,
  output logic                      extRefused,
  output logic      [7:0]           extRdata
);

  dew_pkg::dew_ctrl_s  ctrl_r;
  dew_pkg::dew_unlock_e unl_r;
  logic [7:0]          addrLo_r;
  logic [7:0]          addrHi_r;
  logic [7:0]          data_r;
  logic                acc;
  logic                wrAcc;
  logic                rdAcc;
  logic                eeSel;
  logic                wsReq;
  logic                intStart;
  logic                rdGo;
  logic                extGo;
  logic                extBlock;
  logic                extWrGo;
  logic                arrStart;
  logic [AW-1:0]       intAddr;
  logic [AW-1:0]       arrWrAddr;
  logic [7:0]          arrWrData;
  logic [AW-1:0]       arrRdAddr;
  logic [7:0]          arrRdData;
  logic                busy;
  logic                pwrtDone;

  function automatic logic isMapped(input logic [7:0] a);
    return a == dew_pkg::OFF_CTRL || a == dew_pkg::OFF_ADDR_LO ||
           a == dew_pkg::OFF_ADDR_HI || a == dew_pkg::OFF_DATA ||
           a == dew_pkg::OFF_UNLOCK || a == dew_pkg::OFF_STATUS;
  endfunction : isMapped

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return isMapped(a) && a == off;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, pready comes from a flop

  assign acc   = psel && penable && pready;
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !isMapped(paddr);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= dew_pkg::RST_WORD;
    end else if (psel && !penable) begin
      prdata <= dew_pkg::RST_WORD;
      case (paddr)
        dew_pkg::OFF_CTRL: begin
          prdata[dew_pkg::CB_PMSEL]  <= ctrl_r.pmSel;
          prdata[dew_pkg::CB_CFGSEL] <= ctrl_r.cfgSel;
          prdata[dew_pkg::CB_ERR]    <= ctrl_r.err;
          prdata[dew_pkg::CB_PERMIT] <= ctrl_r.permit;
          prdata[dew_pkg::CB_WSTART] <= busy;
        end
        dew_pkg::OFF_ADDR_LO: prdata[7:0] <= addrLo_r;
        dew_pkg::OFF_ADDR_HI: prdata[7:0] <= addrHi_r;
        dew_pkg::OFF_DATA:    prdata[7:0] <= data_r;
        dew_pkg::OFF_STATUS: begin
          prdata[dew_pkg::SB_PWRT_DONE] <= pwrtDone;
          prdata[dew_pkg::SB_PROTECT]   <= codeProtect;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, address and data registers

  assign eeSel = !ctrl_r.pmSel && !ctrl_r.cfgSel;
  assign wsReq = wrAcc && hit(paddr, dew_pkg::OFF_CTRL) && pwdata[dew_pkg::CB_WSTART];

  // start needs permit, a fresh unlock, the array selected and the timer over
  assign intStart = wsReq && !busy && unl_r == dew_pkg::UNL_ARMED &&
                    ctrl_r.permit && eeSel && pwrtDone;
  assign rdGo     = wrAcc && hit(paddr, dew_pkg::OFF_CTRL) &&
                    pwdata[dew_pkg::CB_READ] && eeSel;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_r <= '0;
    end else if (wrAcc && hit(paddr, dew_pkg::OFF_CTRL)) begin
      ctrl_r.pmSel  <= pwdata[dew_pkg::CB_PMSEL];
      ctrl_r.cfgSel <= pwdata[dew_pkg::CB_CFGSEL];
      ctrl_r.permit <= pwdata[dew_pkg::CB_PERMIT];
      // a refused start sets the flag; that set wins over a clear
      ctrl_r.err    <= (pwdata[dew_pkg::CB_ERR] && ctrl_r.err) || (wsReq && !busy && !intStart);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      addrLo_r <= 8'h00;
      addrHi_r <= 8'h00;
    end else if (wrAcc) begin
      if (hit(paddr, dew_pkg::OFF_ADDR_LO)) addrLo_r <= pwdata[7:0];
      if (hit(paddr, dew_pkg::OFF_ADDR_HI)) addrHi_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      data_r <= 8'h00;
    end else if (rdGo) begin
      data_r <= arrRdData;
    end else if (wrAcc && hit(paddr, dew_pkg::OFF_DATA)) begin
      data_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence: any other register write in between disarms it

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      unl_r <= dew_pkg::UNL_IDLE;
    end else if (busy) begin
      unl_r <= dew_pkg::UNL_IDLE;
    end else if (wrAcc) begin
      if (hit(paddr, dew_pkg::OFF_UNLOCK)) begin
        case (unl_r)
          dew_pkg::UNL_IDLE:
            unl_r <= (pwdata[7:0] == dew_pkg::KEY_FIRST) ? dew_pkg::UNL_GOT_FIRST
                                                          : dew_pkg::UNL_IDLE;
          dew_pkg::UNL_GOT_FIRST:
            unl_r <= (pwdata[7:0] == dew_pkg::KEY_SECOND) ? dew_pkg::UNL_ARMED
                                                           : dew_pkg::UNL_IDLE;
          default:
            unl_r <= dew_pkg::UNL_IDLE;
        endcase
      end else begin
        unl_r <= dew_pkg::UNL_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external programming port; waits while the array is busy

  assign extBlock = codeProtect || (extReq.write && !pwrtDone);
  assign extGo    = extValid && !extAck && !extRefused && !busy && !intStart && !rdGo;
  assign extWrGo  = extGo && !extBlock && extReq.write;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      extAck     <= 1'b0;
      extRefused <= 1'b0;
      extRdata   <= 8'h00;
    end else begin
      extAck     <= extGo && !extBlock;
      extRefused <= extGo && extBlock;
      if (extGo && !extBlock && !extReq.write) extRdata <= arrRdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array

  assign intAddr   = AW'({addrHi_r, addrLo_r});
  assign arrStart  = intStart || extWrGo;
  assign arrWrAddr = intStart ? intAddr : extReq.addr;
  assign arrWrData = intStart ? data_r : extReq.wdata;
  assign arrRdAddr = rdGo ? intAddr : extReq.addr;

  dew_pwrt_timer #(
    .CYC     (PWRT_CYC)
  ) u_pwrt (
    .clock   (clock),
    .reset_n (reset_n),
    .done    (pwrtDone)
  );

  dew_byte_array #(
    .AW      (AW),
    .DW      (8),
    .CYC     (WRITE_CYC)
  ) u_array (
    .clock   (clock),
    .reset_n (reset_n),
    .wrStart (arrStart),
    .wrAddr  (arrWrAddr),
    .wrData  (arrWrData),
    .rdAddr  (arrRdAddr),
    .rdData  (arrRdData),
    .busy    (busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_EXT_PROTECT: assert property (
    extGo && codeProtect |=> extRefused && !extAck && !$rose(busy))
    else $error("external access taken under code protection");

  AST_INT_IGNORES_PROTECT: assert property (
    intStart && codeProtect |=> busy)
    else $error("internal write blocked by code protection");

  AST_PERMIT_CLEARED: assert property (
    !$past(reset_n) |-> !ctrl_r.permit)
    else $error("write permit not clear after reset");

  AST_PWRT_BLOCKS: assert property (
    !pwrtDone |-> !arrStart ##1 !$rose(busy))
    else $error("array write during power-up timer");

  AST_UNLOCK_NEEDED: assert property (
    $rose(busy) |-> $past(extWrGo) ||
      ($past(unl_r) == dew_pkg::UNL_ARMED && $past(ctrl_r.permit)))
    else $error("write started without unlock and permit");

  AST_BUSY_HOLDS: assert property (
    $rose(busy) |-> busy[*8])
    else $error("write start bit cleared too early");

  AST_ADDR_FORM: assert property (
    intStart |-> arrWrAddr == AW'({addrHi_r, addrLo_r}))
    else $error("write address not formed from high and low bytes");

  AST_READ_FETCH: assert property (
    rdGo |=> data_r == $past(arrRdData))
    else $error("read did not fetch addressed byte");

  AST_SELECT: assert property (
    intStart || rdGo |-> !ctrl_r.pmSel && !ctrl_r.cfgSel)
    else $error("access while array not selected");

  AST_BUSY_IGNORES: assert property (
    busy && wsReq |=> unl_r == dew_pkg::UNL_IDLE && busy)
    else $error("start accepted during running write");

  COV_INT_WRITE: cover property (intStart ##1 busy [*2] ##[1:400] !busy);
  COV_EXT_REFUSED: cover property (extValid && codeProtect ##1 extRefused);
  COV_READ: cover property (rdGo);
  COV_REJECT: cover property (wsReq && !busy && !intStart);

endmodule : dew_guard_top

// file: dew_pkg.sv
// dew_pkg: shared constants and types for the data EEPROM write guard
// assumes a 200 MHz system clock and an APB register slave with 32-bit data
package dew_pkg;

  localparam int          CLK_MHZ      = 200;
  localparam int          ADDR_W       = 10;
  localparam int          DATA_W       = 8;

  // power-up timer period and array write time, in ns
  localparam int          PWRT_NS      = 2000;
  localparam int          WRITE_NS     = 1000;
  localparam int          PWRT_CYC     = (PWRT_NS * CLK_MHZ + 999) / 1000;
  localparam int          WRITE_CYC    = (WRITE_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_ADDR_LO  = 8'h04;
  localparam logic [7:0]  OFF_ADDR_HI  = 8'h08;
  localparam logic [7:0]  OFF_DATA     = 8'h0C;
  localparam logic [7:0]  OFF_UNLOCK   = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;

  // nv_control_reg bit positions
  localparam int          CB_READ      = 0;
  localparam int          CB_WSTART    = 1;
  localparam int          CB_PERMIT    = 2;
  localparam int          CB_ERR       = 3;
  localparam int          CB_CFGSEL    = 6;
  localparam int          CB_PMSEL     = 7;

  // status bit positions
  localparam int          SB_PWRT_DONE = 0;
  localparam int          SB_PROTECT   = 1;

  // unlock key values
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;

  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_GOT_FIRST,
    UNL_ARMED
  } dew_unlock_e;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dew_ext_req_s;

  typedef struct packed {
    logic pmSel;
    logic cfgSel;
    logic err;
    logic permit;
  } dew_ctrl_s;

endpackage : dew_pkg

// file: dew_pwrt_timer.sv
// dew_pwrt_timer: counts the power-up timer period after reset release
// assumes reset_n is the power-on reset of the block
`timescale 1ns/1ps
module dew_pwrt_timer #(
  parameter int CYC = dew_pkg::PWRT_CYC
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      done
);

  logic [$clog2(CYC+1)-1:0] cnt_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (!done) begin
      cnt_r <= cnt_r + 1'b1;
      done  <= (cnt_r == ($clog2(CYC+1))'(CYC - 1));
    end
  end

endmodule : dew_pwrt_timer
